// file: rtl/pcie_port_link_slot_regs.sv
// Link and slot configuration registers of one switch port
`timescale 1ns/1ps
// Functional notes
// RULE1 - Power-state field: off, L0s, L1, both
// RULE2 - Link disable: upstream zero, downstream drops link
// RULE3 - Retrain write starts training on downstream only; reads zero
// RULE4 - Read completion boundary always reads zero
// RULE5 - Common clock bit stored, resets zero
// RULE6 - Extended synch: 4096 FTS, 1024 TS1
// RULE7 - Clock PM off holds clock request low
// RULE8 - Bandwidth interrupt enables writable downstream only
// RULE9 - Speed codes 2.5 and 5.0, reset 5.0
// RULE10 - Negotiated width read-only, resets single lane
// RULE11 - Training error set on fail, cleared on L0
// RULE12 - Training bit high during training, resets one
// RULE13 - Link active bit mirrors active data link
// RULE14 - Bandwidth status bits cleared by writing one
// RULE15 - Link active reporting: upstream zero, downstream one
// RULE16 - Port number field resets to port index
// RULE17 - Slot capability flags fixed, read-only
// RULE18 - Power limit write sends power limit message
// RULE19 - Slot event enables permit hot-plug interrupt
// RULE20 - Master hot-plug enable gates all events
// RULE21 - Attention indicator encoding, reset off, message
// RULE22 - Power indicator encoding, reset on, message
// RULE23 - Reserved bits ignore writes, read zero
// RULE24 - Own copy per port; slot regs downstream only
module pcie_port_link_slot_regs import port_regs_pkg::*; #(
    parameter logic [7:0] PORT_INDEX = 8'h00
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Configuration access
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    // Link training and data link state
    input wire logic train_start_i,
    input wire logic train_ok_i,
    input wire logic train_fail_i,
    input wire logic [3:0] neg_speed_i,
    input wire logic [5:0] neg_width_i,
    input wire logic dl_active_i,
    input wire logic bw_mgmt_evt_i,
    input wire logic bw_auto_evt_i,
    input wire logic clk_release_i,
    // Slot pins and hot-plug events
    input wire logic atn_button_pin_i,
    input wire logic presence_pin_i,
    input wire logic pwr_fault_i,
    input wire logic mrl_change_i,
    input wire logic cmd_done_i,
    // Link controls
    output logic [1:0] aspm_ctl_o,
    output logic link_disable_o,
    output logic retrain_o,
    output logic common_clk_o,
    output logic ext_synch_o,
    output logic [12:0] fts_exit_cnt_o,
    output logic [10:0] ts1_exit_cnt_o,
    output logic hw_width_dis_o,
    output logic clkreq_b_o,
    // Slot messages and interrupt
    output logic spl_msg_o,
    output logic [7:0] spl_value_o,
    output logic [1:0] spl_scale_o,
    output logic atn_msg_o,
    output logic [1:0] atn_ind_o,
    output logic pwr_msg_o,
    output logic [1:0] pwr_ind_o,
    output logic hp_irq_o
);
    // Port zero faces upstream, the rest are downstream
    localparam logic IS_DS = (PORT_INDEX != 8'h00); // RULE24

    // All state of the port
    typedef struct packed {
        logic [31:0] rdata;
        logic ack;
        logic [1:0] aspm;
        logic ldis;
        logic retrain;
        logic ccc;
        logic esync;
        logic [12:0] fts_cnt;
        logic [10:0] ts1_cnt;
        logic clkpm;
        logic hawd;
        logic bwm_ie;
        logic bwa_ie;
        logic [3:0] spd;
        logic [5:0] wid;
        logic terr;
        logic trn;
        logic dla;
        logic clkreq_b;
        logic [7:0] splv;
        logic [1:0] spls;
        logic spl_msg;
        logic [4:0] evt_en;
        logic hp_ie;
        logic [1:0] atn;
        logic [1:0] pwr;
        logic atn_msg;
        logic pwr_msg;
        logic hp_irq;
        logic btn_q;
        logic pres_q;
    } port_st_t;

    port_st_t st_reg, st_next;

    // Filtered slot pins
    logic [1:0] pin_lvl;
    // Bandwidth status flags and their clears
    logic [1:0] bw_flag;
    logic [1:0] bw_clr;
    // Decoded writes
    logic wr_lctl;
    logic wr_scap;
    logic wr_sctl;
    logic [31:0] wmask;
    logic [31:0] wval;
    // Read words
    logic [31:0] cap_word;
    logic [31:0] lnk_word;
    logic [31:0] scap_word;
    logic [31:0] sctl_word;
    // Slot events this cycle
    logic [4:0] slot_evt;

    // Slot pins come from outside the clock domain
    pin_sync #(
        .W(2)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({presence_pin_i, atn_button_pin_i}),
        .lvl_o(pin_lvl)
    );

    // Bandwidth status, write one to clear
    sticky_flag #(
        .W(2)
    ) u_bw_flag (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i({bw_auto_evt_i, bw_mgmt_evt_i}),
        .clr_i(bw_clr),
        .flag_o(bw_flag)
    );

    // Write decode and byte lane mask
    always_comb begin
        wr_lctl = cfg_wr_i && (cfg_addr_i[7:2] == OFF_LINK_CTL[7:2]);
        wr_scap = IS_DS && cfg_wr_i && (cfg_addr_i[7:2] == OFF_SLOT_CAP[7:2]); // RULE24
        wr_sctl = IS_DS && cfg_wr_i && (cfg_addr_i[7:2] == OFF_SLOT_CTL[7:2]); // RULE24
        wmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
        wval = cfg_wdata_i & wmask;
        bw_clr[0] = wr_lctl && wval[LS_BWM]; // RULE14
        bw_clr[1] = wr_lctl && wval[LS_BWA]; // RULE14
    end

    // Read words; unnamed bits stay zero
    always_comb begin
        cap_word = '0; // RULE23
        cap_word[CAP_DLLA] = IS_DS; // RULE15
        cap_word[CAP_PNUM_LSB +: 8] = PORT_INDEX; // RULE16
        lnk_word = '0; // RULE23
        lnk_word[LC_ASPM_LSB +: 2] = st_reg.aspm;
        lnk_word[LC_LDIS] = st_reg.ldis;
        lnk_word[LC_CCC] = st_reg.ccc;
        lnk_word[LC_ESYNC] = st_reg.esync;
        lnk_word[LC_CLKPM] = st_reg.clkpm;
        lnk_word[LC_HAWD] = st_reg.hawd;
        lnk_word[LC_BWM_IE] = st_reg.bwm_ie;
        lnk_word[LC_BWA_IE] = st_reg.bwa_ie;
        lnk_word[LS_SPD_LSB +: 4] = st_reg.spd;
        lnk_word[LS_WID_LSB +: 6] = st_reg.wid;
        lnk_word[LS_TERR] = st_reg.terr;
        lnk_word[LS_TRN] = st_reg.trn;
        lnk_word[LS_SCC] = SCC_RST;
        lnk_word[LS_DLA] = st_reg.dla;
        lnk_word[LS_BWM] = bw_flag[0];
        lnk_word[LS_BWA] = bw_flag[1];
        scap_word = '0;
        sctl_word = '0;
        if (IS_DS) begin
            scap_word[6:0] = SLOT_CAP_FLAGS; // RULE17
            scap_word[SC_SPLV_LSB +: 8] = st_reg.splv;
            scap_word[SC_SPLS_LSB +: 2] = st_reg.spls;
            sctl_word[4:0] = st_reg.evt_en;
            sctl_word[SCT_HPIE] = st_reg.hp_ie;
            sctl_word[SCT_ATN_LSB +: 2] = st_reg.atn;
            sctl_word[SCT_PWR_LSB +: 2] = st_reg.pwr;
        end
    end

    // Next-state logic for all registers and outputs
    always_comb begin
        st_next = st_reg;
        st_next.ack = cfg_rd_i || cfg_wr_i;
        st_next.retrain = 1'b0;
        st_next.spl_msg = 1'b0;
        st_next.atn_msg = 1'b0;
        st_next.pwr_msg = 1'b0;
        // Read data capture
        if (cfg_rd_i) begin
            case (cfg_addr_i[7:2])
                OFF_LINK_CAP[7:2]: st_next.rdata = cap_word;
                OFF_LINK_CTL[7:2]: st_next.rdata = lnk_word; // RULE3 RULE4
                OFF_SLOT_CAP[7:2]: st_next.rdata = scap_word;
                OFF_SLOT_CTL[7:2]: st_next.rdata = sctl_word;
                default: st_next.rdata = '0;
            endcase
        end
        // Link control writes
        if (wr_lctl && cfg_be_i[0]) begin
            st_next.aspm = wval[LC_ASPM_LSB +: 2]; // RULE1
            st_next.ldis = IS_DS && wval[LC_LDIS]; // RULE2
            st_next.retrain = IS_DS && wval[LC_RETRAIN]; // RULE3
            st_next.ccc = wval[LC_CCC]; // RULE5
            st_next.esync = wval[LC_ESYNC];
        end
        if (wr_lctl && cfg_be_i[1]) begin
            st_next.clkpm = !IS_DS && wval[LC_CLKPM]; // RULE7
            st_next.hawd = wval[LC_HAWD];
            if (IS_DS) begin
                st_next.bwm_ie = wval[LC_BWM_IE]; // RULE8
                st_next.bwa_ie = wval[LC_BWA_IE]; // RULE8
            end
        end
        // Ordered set counts follow extended synch
        st_next.fts_cnt = st_next.esync ? EXT_FTS_CNT : 13'h0000; // RULE6
        st_next.ts1_cnt = st_next.esync ? EXT_TS1_CNT : 11'h000; // RULE6
        // Clock request held low unless clock PM enabled
        st_next.clkreq_b = st_reg.clkpm && clk_release_i; // RULE7
        // Training status
        if (train_start_i || st_reg.retrain) begin
            st_next.trn = 1'b1; // RULE12
        end
        if (train_ok_i) begin
            st_next.trn = 1'b0; // RULE12
            st_next.terr = 1'b0; // RULE11
            st_next.spd = neg_speed_i; // RULE9
            st_next.wid = neg_width_i; // RULE10
        end
        if (train_fail_i) begin
            st_next.trn = 1'b0; // RULE12
            st_next.terr = 1'b1; // RULE11
        end
        st_next.dla = dl_active_i; // RULE13
        // Slot power limit writes
        if (wr_scap && (cfg_be_i[2:0] != 3'h0)) begin
            if (cfg_be_i[0]) begin
                st_next.splv[0] = wval[SC_SPLV_LSB];
            end
            if (cfg_be_i[1]) begin
                st_next.splv[7:1] = wval[SC_SPLV_LSB+1 +: 7];
                st_next.spls[0] = wval[SC_SPLS_LSB];
            end
            if (cfg_be_i[2]) begin
                st_next.spls[1] = wval[SC_SPLS_LSB+1];
            end
            st_next.spl_msg = 1'b1; // RULE18
        end
        // Slot control writes
        if (wr_sctl && cfg_be_i[0]) begin
            st_next.evt_en = wval[4:0]; // RULE19
            st_next.hp_ie = wval[SCT_HPIE]; // RULE20
            st_next.atn = wval[SCT_ATN_LSB +: 2];
            st_next.atn_msg = 1'b1; // RULE21
        end
        if (wr_sctl && cfg_be_i[1]) begin
            st_next.pwr = wval[SCT_PWR_LSB +: 2];
            st_next.pwr_msg = 1'b1; // RULE22
        end
        // Hot-plug events gated by their enables
        st_next.btn_q = pin_lvl[0];
        st_next.pres_q = pin_lvl[1];
        st_next.hp_irq = IS_DS && st_reg.hp_ie && ((slot_evt & st_reg.evt_en) != 5'h00); // RULE19 RULE20
    end

    // Button press is a rising edge, presence change any edge
    always_comb begin
        slot_evt = {cmd_done_i, pin_lvl[1] ^ st_reg.pres_q, mrl_change_i, pwr_fault_i,
            pin_lvl[0] & ~st_reg.btn_q};
    end

    // State register with documented reset values
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.aspm <= ASPM_RST; // RULE1
            st_reg.spd <= SPD_RST; // RULE9
            st_reg.wid <= WID_RST; // RULE10
            st_reg.trn <= 1'b1; // RULE12
            st_reg.splv <= SPLV_RST; // RULE18
            st_reg.spls <= SPLS_RST;
            st_reg.atn <= ATN_RST; // RULE21
            st_reg.pwr <= PWR_RST; // RULE22
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign cfg_rdata_o = st_reg.rdata;
    assign cfg_ack_o = st_reg.ack;
    assign aspm_ctl_o = st_reg.aspm;
    assign link_disable_o = st_reg.ldis;
    assign retrain_o = st_reg.retrain;
    assign common_clk_o = st_reg.ccc;
    assign ext_synch_o = st_reg.esync;
    assign fts_exit_cnt_o = st_reg.fts_cnt;
    assign ts1_exit_cnt_o = st_reg.ts1_cnt;
    assign hw_width_dis_o = st_reg.hawd;
    assign clkreq_b_o = st_reg.clkreq_b;
    assign spl_msg_o = st_reg.spl_msg;
    assign spl_value_o = st_reg.splv;
    assign spl_scale_o = st_reg.spls;
    assign atn_msg_o = st_reg.atn_msg;
    assign atn_ind_o = st_reg.atn;
    assign pwr_msg_o = st_reg.pwr_msg;
    assign pwr_ind_o = st_reg.pwr;
    assign hp_irq_o = st_reg.hp_irq;

    // Checks on the register behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    ldis_upstream_a: assert property (!IS_DS |-> !link_disable_o) // RULE2
        else $error("link disable set on upstream port");
    retrain_pulse_a: assert property (retrain_o |=> !retrain_o) // RULE3
        else $error("retrain request longer than one cycle");
    retrain_read_a: assert property (cfg_rd_i && cfg_addr_i[7:2] == OFF_LINK_CTL[7:2]
        |=> !cfg_rdata_o[LC_RETRAIN] && !cfg_rdata_o[3]) // RULE4
        else $error("retrain or completion boundary read as one");
    clkreq_low_a: assert property (!st_reg.clkpm |=> !clkreq_b_o) // RULE7
        else $error("clock request released with clock PM off");
    fts_count_a: assert property (ext_synch_o |-> fts_exit_cnt_o == 13'h1000
        && ts1_exit_cnt_o == 11'h400) // RULE6
        else $error("extended synch counts wrong");
    train_err_a: assert property (train_fail_i |=> st_reg.terr && !st_reg.trn) // RULE11
        else $error("training failure not recorded");
    train_ok_a: assert property (train_ok_i && !train_fail_i |=> !st_reg.terr
        && !st_reg.trn && st_reg.wid == $past(neg_width_i)) // RULE12
        else $error("training completion not recorded");
    dla_follow_a: assert property (st_reg.dla == $past(dl_active_i)) // RULE13
        else $error("link active bit does not follow data link");
    spl_msg_a: assert property (wr_scap && cfg_be_i[2:0] != 3'h0 |=> spl_msg_o) // RULE18
        else $error("power limit write sent no message");
    hp_gate_a: assert property (!st_reg.hp_ie |=> !hp_irq_o) // RULE20
        else $error("hot-plug interrupt without master enable");
    ind_msg_a: assert property (wr_sctl && cfg_be_i[0] |=> atn_msg_o
        && atn_ind_o == $past(cfg_wdata_i[7:6])) // RULE21
        else $error("attention indicator write not sent");
    pwr_msg_a: assert property (wr_sctl && cfg_be_i[1] |=> pwr_msg_o) // RULE22
        else $error("power indicator write not sent");
endmodule

// file: rtl/port_regs_pkg.sv
// Shared offsets, field positions, reset values and counts for the port registers
package port_regs_pkg;
    // Register byte offsets in configuration space
    localparam logic [7:0] OFF_LINK_CAP = 8'hCC;
    localparam logic [7:0] OFF_LINK_CTL = 8'hD0;
    localparam logic [7:0] OFF_SLOT_CAP = 8'hD4;
    localparam logic [7:0] OFF_SLOT_CTL = 8'hD8;
    // Link capabilities upper fields
    localparam int CAP_DLLA = 20;
    localparam int CAP_PNUM_LSB = 24;
    // Link control fields
    localparam int LC_ASPM_LSB = 0;
    localparam int LC_LDIS = 4;
    localparam int LC_RETRAIN = 5;
    localparam int LC_CCC = 6;
    localparam int LC_ESYNC = 7;
    localparam int LC_CLKPM = 8;
    localparam int LC_HAWD = 9;
    localparam int LC_BWM_IE = 10;
    localparam int LC_BWA_IE = 11;
    // Link status fields
    localparam int LS_SPD_LSB = 16;
    localparam int LS_WID_LSB = 20;
    localparam int LS_TERR = 26;
    localparam int LS_TRN = 27;
    localparam int LS_SCC = 28;
    localparam int LS_DLA = 29;
    localparam int LS_BWM = 30;
    localparam int LS_BWA = 31;
    // Slot capabilities fields
    localparam int SC_SPLV_LSB = 7;
    localparam int SC_SPLS_LSB = 15;
    // Slot control fields
    localparam int SCT_HPIE = 5;
    localparam int SCT_ATN_LSB = 6;
    localparam int SCT_PWR_LSB = 8;
    // Power-state control encodings
    localparam logic [1:0] ASPM_OFF = 2'h0;
    localparam logic [1:0] ASPM_L0S = 2'h1;
    localparam logic [1:0] ASPM_L1 = 2'h2;
    localparam logic [1:0] ASPM_BOTH = 2'h3;
    // Indicator encodings
    localparam logic [1:0] IND_ON = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF = 2'h3;
    // Speed codes
    localparam logic [3:0] SPD_2G5 = 4'h1;
    localparam logic [3:0] SPD_5G0 = 4'h2;
    // Reset values
    localparam logic [1:0] ASPM_RST = ASPM_OFF;
    localparam logic [3:0] SPD_RST = SPD_5G0;
    localparam logic [5:0] WID_RST = 6'h01;
    localparam logic SCC_RST = 1'b1;
    localparam logic [7:0] SPLV_RST = 8'h19;
    localparam logic [1:0] SPLS_RST = 2'h0;
    localparam logic [1:0] ATN_RST = IND_OFF;
    localparam logic [1:0] PWR_RST = IND_ON;
    localparam logic [6:0] SLOT_CAP_FLAGS = 7'h5F;
    // Extended synch ordered set counts
    localparam logic [12:0] EXT_FTS_CNT = 13'h1000;
    localparam logic [10:0] EXT_TS1_CNT = 11'h400;
endpackage

// file: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync import port_regs_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Pins and filtered levels
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] lvl_o
);
    // All flops of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_st_t;

    sync_st_t st_reg, st_next;

    // Shift chain; level follows once stages two and three agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.lvl[i] = st_reg.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lvl_o = st_reg.lvl;
endmodule

// file: rtl/sticky_flag.sv
// Sticky status flags, set by hardware, cleared by writing one
`timescale 1ns/1ps
module sticky_flag import port_regs_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Set events and clear strobes
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flag_o
);
    // Flag storage
    typedef struct packed {
        logic [W-1:0] flag;
    } flag_st_t;

    flag_st_t st_reg, st_next;

    // Set wins over a clear in the same cycle
    always_comb begin
        st_next = st_reg;
        st_next.flag = set_i | (st_reg.flag & ~clr_i);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_o = st_reg.flag;
endmodule

// file: dv/link_partner.sv
// Behavioural link partner driving training and bandwidth events
`timescale 1ns/1ps
module link_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Command: 1 start, 2 ok, 3 fail, 4 bandwidth events
    input wire logic [2:0] cmd_i,
    // Event pulses and link state
    output logic train_start_o,
    output logic train_ok_o,
    output logic train_fail_o,
    output logic bw_evt_o,
    output logic dl_active_o
);
    logic [1:0] up_dly; // Delay from trained link to active data link
    // One-cycle pulses per command; data link rises two cycles after L0
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {train_start_o, train_ok_o, train_fail_o, bw_evt_o, dl_active_o} <= '0;
            up_dly <= '0;
        end else begin
            train_start_o <= (cmd_i == 3'h1);
            train_ok_o <= (cmd_i == 3'h2);
            train_fail_o <= (cmd_i == 3'h3);
            bw_evt_o <= (cmd_i == 3'h4);
            up_dly <= {up_dly[0], cmd_i == 3'h2};
            // Link lost on any new training attempt
            if (cmd_i == 3'h1 || cmd_i == 3'h3) begin
                dl_active_o <= 1'b0;
            end else if (up_dly[1]) begin
                dl_active_o <= 1'b1;
            end
        end
    end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for an upstream and a downstream port register bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top import port_regs_pkg::*;;
    typedef struct {logic chk; logic [31:0] e_dn; logic [31:0] e_up;} note_t;
    logic clk_i = 0, rst_b_i = 0, rd = 0, wr = 0;
    logic [7:0] addr = '0;
    logic [3:0] be = '0, spd = SPD_5G0;
    logic [31:0] wd = '0;
    logic [5:0] wid = WID_RST;
    logic [2:0] cmd = '0;
    logic clk_rel = 0;
    // Slot inputs: button, fault, latch, presence, command done
    logic [4:0] sev = '0;
    logic ts, tk, tf, bw, dla, r;
    wire [1:0] ack, ldis, rt, es, hwd, spl, atn, pwr, irq, ccc, clkreq;
    wire [31:0] rdat [2];
    wire [1:0] aspm [2], spls [2], atni [2], pwri [2];
    wire [12:0] fts [2];
    wire [10:0] ts1 [2];
    wire [7:0] splv [2];
    int cnt_rt [2], cnt_spl [2], cnt_atn [2], cnt_pwr [2], cnt_irq [2];
    int mismatches = 0, samples_checked = 0;
    note_t q [$];
    note_t n;
    // Core clock, 100 ns period
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    link_partner i_link_partner (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd),
        .train_start_o(ts), .train_ok_o(tk), .train_fail_o(tf), .bw_evt_o(bw),
        .dl_active_o(dla));
    // Index 0 downstream port 5, index 1 upstream port 0
    for (genvar g = 0; g < 2; g++) begin : gp
        pcie_port_link_slot_regs #(.PORT_INDEX(g ? 8'h00 : 8'h05)) i_pcie_port_link_slot_regs (
            .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_rd_i(rd), .cfg_wr_i(wr),
            .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd),
            .cfg_rdata_o(rdat[g]), .cfg_ack_o(ack[g]),
            .train_start_i(ts), .train_ok_i(tk), .train_fail_i(tf), .neg_speed_i(spd),
            .neg_width_i(wid), .dl_active_i(dla), .bw_mgmt_evt_i(bw), .bw_auto_evt_i(bw),
            .clk_release_i(clk_rel), .atn_button_pin_i(sev[0]), .presence_pin_i(sev[3]),
            .pwr_fault_i(sev[1]), .mrl_change_i(sev[2]), .cmd_done_i(sev[4]),
            .aspm_ctl_o(aspm[g]), .link_disable_o(ldis[g]), .retrain_o(rt[g]),
            .common_clk_o(ccc[g]), .ext_synch_o(es[g]), .fts_exit_cnt_o(fts[g]),
            .ts1_exit_cnt_o(ts1[g]), .hw_width_dis_o(hwd[g]), .clkreq_b_o(clkreq[g]),
            .spl_msg_o(spl[g]), .spl_value_o(splv[g]), .spl_scale_o(spls[g]),
            .atn_msg_o(atn[g]), .atn_ind_o(atni[g]), .pwr_msg_o(pwr[g]),
            .pwr_ind_o(pwri[g]), .hp_irq_o(irq[g]));
    end
    // Pulse counters per port
    always @(posedge clk_i) begin
        for (int g = 0; g < 2; g++) begin
            cnt_rt[g] += (rt[g] === 1'b1);
            cnt_spl[g] += (spl[g] === 1'b1);
            cnt_atn[g] += (atn[g] === 1'b1);
            cnt_pwr[g] += (pwr[g] === 1'b1);
            cnt_irq[g] += (irq[g] === 1'b1);
        end
    end
    // Oldest note checked against each acknowledge
    always @(negedge clk_i) begin
        if (ack[0] === 1'b1 && q.size() > 0) begin
            n = q.pop_front();
            `CHK(ack[1], 1'b1)
            if (n.chk) begin
                `CHK(rdat[0], n.e_dn)
                `CHK(rdat[1], n.e_up)
            end
        end
    end
    // One access, acknowledged one cycle later
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d, input logic [31:0] edn, input logic [31:0] eup);
        q.push_back('{!w, edn, eup});
        @(posedge clk_i);
        {wr, rd, addr, be, wd} <= {w, !w, a, b, d};
        @(posedge clk_i);
        {wr, rd} <= 2'b00;
        repeat (2) @(posedge clk_i);
    endtask
    // Slot input k high for len cycles; pins need 2 to pass the filter
    task automatic pulse(input int k, input int len);
        @(posedge clk_i);
        sev[k] <= 1'b1;
        repeat (len) @(posedge clk_i);
        sev[k] <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic link(input logic [2:0] c);
        @(posedge clk_i);
        cmd <= c;
        @(posedge clk_i);
        cmd <= '0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #3000000;
        mismatches++;
        close_out();
    end
    // Main sequence
    initial begin
        void'($urandom(2));
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        acc(0, OFF_LINK_CAP, 4'hF, 0, 32'h0510_0000, 0);
        acc(0, OFF_LINK_CTL, 4'hF, 0, 32'h1812_0000, 32'h1812_0000);
        acc(0, OFF_SLOT_CAP, 4'hF, 0, 32'h0000_0CDF, 0);
        acc(0, OFF_SLOT_CTL, 4'hF, 0, 32'h0000_01C0, 0);
        acc(0, 8'hE0, 4'hF, 0, 0, 0);
        clk_rel <= 1'b1;
        acc(1, OFF_LINK_CTL, 4'h3, 32'hFFFF, 0, 0);
        acc(0, OFF_LINK_CTL, 4'hF, 0, 32'h1812_0ED3, 32'h1812_03C3);
        `CHK(ldis, 2'b01)
        `CHK(cnt_rt[0] * 2 + cnt_rt[1], 2)
        `CHK({fts[0], ts1[0]}, {EXT_FTS_CNT, EXT_TS1_CNT})
        `CHK(clkreq[0], 1'b0)
        `CHK(clkreq[1], 1'b1)
        `CHK(hwd, 2'b11)
        `CHK(es, 2'b11)
        for (int c = 0; c < 4; c++) begin
            r = $urandom_range(1);
            acc(1, OFF_LINK_CTL, 4'h1, {r, 6'h00} | c, 0, 0);
            `CHK(aspm[0], c[1:0])
            `CHK(aspm[1], c[1:0])
            `CHK(ccc[0], r)
        end
        `CHK(fts[1], 13'h0)
        acc(1, OFF_LINK_CTL, 4'h2, 0, 0, 0);
        `CHK(clkreq[1], 1'b0)
        link(3);
        acc(0, OFF_LINK_CTL, 4'hF, 0, 32'h1412_0003 | {r, 6'h0},
            32'h1412_0003 | {r, 6'h0});
        spd <= SPD_2G5;
        wid <= 6'h04;
        link(2);
        link(4);
        acc(0, OFF_LINK_CTL, 4'hF, 0, 32'hF041_0003 | {r, 6'h0}, 32'hF041_0003 | {r, 6'h0});
        acc(1, OFF_LINK_CTL, 4'h8, 32'hC000_0000, 0, 0);
        link(1);
        acc(0, OFF_LINK_CTL, 4'hF, 0, 32'h1841_0003 | {r, 6'h0},
            32'h1841_0003 | {r, 6'h0});
        acc(1, OFF_SLOT_CAP, 4'h7, 32'h00FF_1D00, 0, 0);
        acc(0, OFF_SLOT_CAP, 4'hF, 0, 32'h0001_1D5F, 0);
        `CHK({cnt_spl[0], cnt_spl[1]}, {32'd1, 32'd0})
        `CHK({splv[0], spls[0]}, {8'h3A, 2'h2})
        acc(1, OFF_SLOT_CTL, 4'h3, 32'hFE7F, 0, 0);
        acc(0, OFF_SLOT_CTL, 4'hF, 0, 32'h0000_027F, 0);
        `CHK({atni[0], pwri[0]}, {IND_ON, IND_BLINK})
        `CHK({cnt_atn[0], cnt_pwr[0], cnt_atn[1]}, {32'd1, 32'd1, 32'd0})
        pulse(1, 1);
        pulse(3, 4);
        pulse(0, 4);
        `CHK({cnt_irq[0], cnt_irq[1]}, {32'd4, 32'd0})
        acc(1, OFF_SLOT_CTL, 4'h1, 32'h5F, 0, 0);
        pulse(4, 1);
        pulse(2, 1);
        `CHK(cnt_irq[0], 4)
        `CHK(cnt_atn[0], 2)
        acc(1, OFF_SLOT_CTL, 4'h1, 32'h7D, 0, 0);
        pulse(1, 1);
        pulse(4, 1);
        pulse(2, 1);
        `CHK(cnt_irq[0], 6)
        `CHK(cnt_atn[0], 3)
        close_out();
    end
endmodule
